/* design/bpsc_pkg.sv */
// constants shared by the buck power state control block
package bpsc_pkg;

    // clock rate and times
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned T_DEGLITCH_US = 34;
    localparam int unsigned DEGLITCH_CYCLES = T_DEGLITCH_US * CLK_MHZ;
    localparam int unsigned T_DELAY_US = 200;
    localparam int unsigned T_RAMP_US = 500;

    // serial bus target address (7 bit) and register offsets
    localparam logic [6:0] TARGET_ADDR = 7'h21;
    localparam logic [7:0] REG_VOUT = 8'h01;
    localparam logic [7:0] REG_CTRL = 8'h03;
    localparam logic [7:0] REG_STATUS = 8'h05;

    // register reset values and field positions
    localparam logic [7:0] VOUT_RESET = 8'h64;
    localparam logic [7:0] CTRL_RESET = 8'h6F;
    localparam int unsigned CTRL_FORCED_PULSE_WIDTH_OPERATION_BIT = 4;
    localparam int unsigned STAT_WARN_BIT = 0;
    localparam int unsigned STAT_INPUT_UNDERVOLTAGE_LOCKOUT_BIT = 1;

    // output level arithmetic in millivolts
    localparam logic [10:0] VOUT_BASE_MV = 11'h190;
    localparam logic [10:0] VOUT_STEP_MV = 11'h005;
    localparam logic [10:0] FB_REF_MV = 11'h258;
    localparam logic [3:0] R2D_RESERVED = 4'hA;

    // resistor level to fixed output millivolts, zero means adjustable
    function automatic logic [10:0] bpsc_r2d_mv(input logic [3:0] level);
        logic [10:0] mv;
        mv = 11'h000;
        unique case (level)
            4'h1: mv = 11'h190;
            4'h2: mv = 11'h1C2;
            4'h3: mv = 11'h1F4;
            4'h4: mv = 11'h258;
            4'h5: mv = 11'h2BC;
            4'h6: mv = 11'h320;
            4'h7: mv = 11'h352;
            4'h8: mv = 11'h384;
            4'h9: mv = 11'h3E8;
            4'hB: mv = 11'h4B0;
            4'hC: mv = 11'h546;
            4'hD: mv = 11'h5DC;
            4'hE: mv = 11'h640;
            default: mv = 11'h000;
        endcase
        return mv;
    endfunction

endpackage

/* design/bpsc_sync.sv */
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
`default_nettype none
module bpsc_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // levels
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    // first stage is read by the second stage only
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_r <= '0;
            q_r <= '0;
        end
        else
        begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule
`default_nettype wire

/* design/bpsc_deglitch.sv */
// deglitch filter: output follows input only after it held steady
`timescale 1ns/10ps
`default_nettype none
module bpsc_deglitch
    import bpsc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // filtered level
    input wire logic d,
    output logic q
);
    logic [10:0] cnt_r;
    logic q_r;

    // count cycles of disagreement, flip when the full time is reached
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_r <= 11'h000;
            q_r <= 1'b0;
        end
        else if (d == q_r)
            cnt_r <= 11'h000;
        else if (cnt_r == 11'(DEGLITCH_CYCLES - 1))
        begin
            cnt_r <= 11'h000;
            q_r <= d;
        end
        else
            cnt_r <= cnt_r + 11'h001;
    end

    assign q = q_r;

    a_pg_deglitch_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (q_r != $past(q_r)) |-> ($past(cnt_r) == 11'(DEGLITCH_CYCLES - 1)))
        else $error("filter output changed before the deglitch time");
endmodule
`default_nettype wire

/* design/bpsc_power_ctrl.sv */
// supervisory state control of the step-down converter with serial target
// Function
// - over shutdown temperature: thermal shutdown, stop switching, discharge on
// - thermal shutdown keeps registers; cooling below hysteresis restarts with soft start
// - serial variant sets warning flag at warning temperature, keeps running
// - enable high runs the device; low shuts switching and control off
// - discharge on when enable low, supply in lockout, or thermal shutdown
// - power-good window changes pass a 34 us deglitch filter; state changes act on power-good at once
// - power-good released inside 0.9 to 1.1 of nominal, low outside
// - pin variant samples select resistor during enable delay and latches it
// - decoder maps levels to 1.60 V down to 0.40 V, ends adjustable
// - reference is feedback 0.6 V when adjustable, else the fixed level
// - sensing current source off once decoding finishes
// - pin variant, after start-up: select pin high forces pulse width, low power save; serial variant uses control bit 4
// - serial variant starts at 0.9 V and answers at 7-bit address 0x21
// - target only; standard, fast, fast plus and high speed rates
// - both lines driven only open drain; idle bus sits high
// - registers kept while supply stays above 1.8 V and enable stays high
// - registers return to defaults on enable fall or supply below 1.8 V
// - serial variant sets lockout flag when supply falls under lockout
`timescale 1ns/10ps
`default_nettype none
module bpsc_power_ctrl
    import bpsc_pkg::*;
#(
    parameter int unsigned DELAY_CYCLES = T_DELAY_US * CLK_MHZ,
    parameter int unsigned RAMP_CYCLES = T_RAMP_US * CLK_MHZ
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // pins and analog comparators, asynchronous
    input wire logic enable_pin,
    input wire logic supply_above_1v8,
    input wire logic input_undervoltage_lockout,
    input wire logic temp_over_shutdown,
    input wire logic temp_below_release,
    input wire logic temp_over_warning,
    input wire logic vout_in_window,
    input wire logic voltage_select_mode_pin,
    input wire logic variant_serial,
    input wire logic [3:0] r2d_level,
    // serial bus pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // converter controls
    output logic switching_on,
    output logic discharge_on,
    output logic soft_start_active,
    output logic thermal_shutdown_active,
    output logic forced_pulse_width_operation,
    output logic r2d_source_on,
    output logic ea_ref_fixed,
    output logic [10:0] ea_ref_mv,
    output logic config_reserved,
    // power-good open drain
    output logic power_good_output_o,
    output logic power_good_output_oe
);
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_DELAY = 3'b001,
        ST_RAMP = 3'b010,
        ST_RUN = 3'b011,
        ST_TSD = 3'b100
    } bpsc_state_t;

    typedef enum logic [2:0] {
        I_IDLE = 3'b000,
        I_ADDR = 3'b001,
        I_REG = 3'b010,
        I_WDATA = 3'b011,
        I_RDATA = 3'b100
    } bpsc_bus_t;

    logic [10:0] pin_s;
    logic [3:0] lvl_s;
    logic en_s, supply_s, input_undervoltage_lockout_s, tsd_s, rel_s, warn_s, win_s, vsel_s, variant_s, scl_s, sda_s;
    bpsc_state_t state_r, state_nxt;
    bpsc_bus_t ist_r;
    logic [23:0] timer_r;
    logic en_d_r, reg_clear, cfg_valid_r, latch_now;
    logic [3:0] cfg_level_r;
    logic pg_filt;
    logic scl_d_r, sda_d_r, scl_rise, scl_fall, start_det, stop_det, ack_end;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r, reg_ptr_r, rd_data;
    logic in_ack_r, sda_low_r, rw_r, wr_stb, rd_status;
    logic [7:0] vout_code_r, ctrl_r;
    logic warn_flag_r, input_undervoltage_lockout_flag_r;
    logic switching_on_r, discharge_on_r, soft_start_r, tsd_active_r, forced_pulse_width_operation_r, r2d_on_r;
    logic ea_fixed_r, reserved_r, pg_oe_r;
    logic [10:0] ea_mv_r;

    // all pin inputs pass two flip-flops
    bpsc_sync #(.WIDTH(11)) u_pin_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .d({enable_pin, supply_above_1v8, input_undervoltage_lockout, temp_over_shutdown,
            temp_below_release, temp_over_warning, vout_in_window, voltage_select_mode_pin,
            variant_serial, scl_i, sda_i}),
        .q(pin_s)
    );
    bpsc_sync #(.WIDTH(4)) u_lvl_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .d(r2d_level),
        .q(lvl_s)
    );
    assign {en_s, supply_s, input_undervoltage_lockout_s, tsd_s, rel_s, warn_s, win_s, vsel_s, variant_s, scl_s,
            sda_s} = pin_s;

    // power-good window level filtered before use
    bpsc_deglitch u_pg_filter (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .d(win_s),
        .q(pg_filt)
    );

    // power state sequence
    always_comb
    begin
        state_nxt = state_r;
        if (!en_s || input_undervoltage_lockout_s || !supply_s)
            state_nxt = ST_OFF;
        else
        begin
            unique case (state_r)
                ST_OFF: state_nxt = ST_DELAY;
                ST_DELAY:
                    if (tsd_s)
                        state_nxt = ST_TSD;
                    else if (timer_r == 24'(DELAY_CYCLES - 1))
                        state_nxt = ST_RAMP;
                ST_RAMP:
                    if (tsd_s)
                        state_nxt = ST_TSD;
                    else if (timer_r == 24'(RAMP_CYCLES - 1))
                        state_nxt = ST_RUN;
                ST_RUN:
                    if (tsd_s)
                        state_nxt = ST_TSD;
                ST_TSD:
                    if (rel_s)
                        state_nxt = ST_RAMP;
                default: state_nxt = ST_OFF;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            state_r <= ST_OFF;
        else
            state_r <= state_nxt;
    end

    // phase timer restarts on every state change
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            timer_r <= 24'h00_0000;
        else if (state_nxt != state_r)
            timer_r <= 24'h00_0000;
        else
            timer_r <= timer_r + 24'h00_0001;
    end

    // resistor decode: sample at end of enable delay, hold until enable drops
    assign latch_now = (state_r == ST_DELAY) && !cfg_valid_r
        && ((state_nxt == ST_RAMP) || (state_nxt == ST_TSD)); // no soft start unlatched
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg_valid_r <= 1'b0;
            cfg_level_r <= 4'h0;
            r2d_on_r <= 1'b0;
        end
        else
        begin
            if (!en_s)
                cfg_valid_r <= 1'b0;
            else if (latch_now)
            begin
                cfg_valid_r <= 1'b1;
                cfg_level_r <= lvl_s;
            end
            r2d_on_r <= (state_nxt == ST_DELAY) && !cfg_valid_r && !latch_now;
        end
    end

    // register defaults return on enable fall or supply collapse
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            en_d_r <= 1'b0;
        else
            en_d_r <= en_s;
    end
    assign reg_clear = (en_d_r && !en_s) || !supply_s;

    // bus edge and condition detection on synchronised lines
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end
    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;
    assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign stop_det = scl_s && scl_d_r && !sda_d_r && sda_s;
    assign ack_end = variant_s && !stop_det && !start_det && scl_fall && in_ack_r
        && (bit_cnt_r == 4'h0);
    assign wr_stb = ack_end && (ist_r == I_WDATA);
    assign rd_status = ack_end && (reg_ptr_r == REG_STATUS)
        && (((ist_r == I_ADDR) && rw_r) || (ist_r == I_RDATA));

    // read data; unmapped offsets read zero
    always_comb
    begin
        rd_data = 8'h00;
        if (reg_ptr_r == REG_VOUT)
            rd_data = vout_code_r;
        else if (reg_ptr_r == REG_CTRL)
            rd_data = ctrl_r;
        else if (reg_ptr_r == REG_STATUS)
        begin
            rd_data[STAT_WARN_BIT] = warn_flag_r;
            rd_data[STAT_INPUT_UNDERVOLTAGE_LOCKOUT_BIT] = input_undervoltage_lockout_flag_r;
        end
    end

    // serial target: bits in on clock rise, data line changed on clock fall
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ist_r <= I_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            reg_ptr_r <= 8'h00;
            in_ack_r <= 1'b0;
            sda_low_r <= 1'b0;
            rw_r <= 1'b0;
        end
        else if (!variant_s || stop_det)
        begin
            ist_r <= I_IDLE;
            in_ack_r <= 1'b0;
            sda_low_r <= 1'b0;
        end
        else if (start_det)
        begin
            ist_r <= I_ADDR;
            bit_cnt_r <= 4'h0;
            in_ack_r <= 1'b0;
            sda_low_r <= 1'b0;
        end
        else if (scl_rise)
        begin
            if (bit_cnt_r == 4'h8)
            begin
                bit_cnt_r <= 4'h0;
                if ((ist_r == I_RDATA) && sda_s)
                    ist_r <= I_IDLE; // controller declined more data
            end
            else
            begin
                shift_r <= {shift_r[6:0], sda_s};
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
        end
        else if (scl_fall)
        begin
            if ((bit_cnt_r == 4'h8) && !in_ack_r)
            begin
                in_ack_r <= 1'b1;
                unique case (ist_r)
                    I_ADDR:
                        if (shift_r[7:1] == TARGET_ADDR)
                        begin
                            sda_low_r <= 1'b1;
                            rw_r <= shift_r[0];
                        end
                        else
                            ist_r <= I_IDLE; // other targets and high-speed code
                    I_REG:
                    begin
                        reg_ptr_r <= shift_r;
                        sda_low_r <= 1'b1;
                    end
                    I_WDATA: sda_low_r <= 1'b1;
                    I_RDATA: sda_low_r <= 1'b0;
                    I_IDLE: sda_low_r <= 1'b0;
                    default: ist_r <= I_IDLE;
                endcase
            end
            else if (ack_end)
            begin
                in_ack_r <= 1'b0;
                sda_low_r <= 1'b0;
                if ((ist_r == I_ADDR) && rw_r)
                begin
                    ist_r <= I_RDATA;
                    shift_r <= rd_data;
                    sda_low_r <= !rd_data[7];
                end
                else if (ist_r == I_ADDR)
                    ist_r <= I_REG;
                else if (ist_r == I_REG)
                    ist_r <= I_WDATA;
                else if (ist_r == I_RDATA)
                begin
                    shift_r <= rd_data;
                    sda_low_r <= !rd_data[7];
                end
            end
            else if ((ist_r == I_RDATA) && !in_ack_r)
                sda_low_r <= !shift_r[7];
        end
    end

    // writable registers: kept in thermal shutdown, defaults on clear
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            vout_code_r <= VOUT_RESET;
            ctrl_r <= CTRL_RESET;
        end
        else if (reg_clear)
        begin
            vout_code_r <= VOUT_RESET;
            ctrl_r <= CTRL_RESET;
        end
        else if (wr_stb && (reg_ptr_r == REG_VOUT))
            vout_code_r <= shift_r;
        else if (wr_stb && (reg_ptr_r == REG_CTRL))
            ctrl_r <= shift_r;
    end

    // sticky status flags, cleared by a status read, set wins
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            warn_flag_r <= 1'b0;
            input_undervoltage_lockout_flag_r <= 1'b0;
        end
        else
        begin
            if (variant_s && warn_s)
                warn_flag_r <= 1'b1;
            else if (rd_status || reg_clear)
                warn_flag_r <= 1'b0;
            if (variant_s && input_undervoltage_lockout_s)
                input_undervoltage_lockout_flag_r <= 1'b1;
            else if (rd_status || reg_clear)
                input_undervoltage_lockout_flag_r <= 1'b0;
        end
    end

    // converter control outputs
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            switching_on_r <= 1'b0;
            discharge_on_r <= 1'b1;
            soft_start_r <= 1'b0;
            tsd_active_r <= 1'b0;
            forced_pulse_width_operation_r <= 1'b0;
        end
        else
        begin
            switching_on_r <= (state_r == ST_RAMP) || (state_r == ST_RUN);
            discharge_on_r <= !en_s || input_undervoltage_lockout_s || (state_r == ST_TSD);
            soft_start_r <= (state_r == ST_RAMP);
            tsd_active_r <= (state_r == ST_TSD);
            forced_pulse_width_operation_r <= (state_r == ST_RUN)
                && (variant_s ? ctrl_r[CTRL_FORCED_PULSE_WIDTH_OPERATION_BIT] : vsel_s);
        end
    end

    // error amplifier reference selection
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ea_fixed_r <= 1'b0;
            ea_mv_r <= 11'h000;
            reserved_r <= 1'b0;
        end
        else if (variant_s)
        begin
            ea_fixed_r <= 1'b1;
            ea_mv_r <= VOUT_BASE_MV + ({3'b000, vout_code_r} * VOUT_STEP_MV);
            reserved_r <= 1'b0;
        end
        else
        begin
            ea_fixed_r <= (bpsc_r2d_mv(cfg_level_r) != 11'h000);
            ea_mv_r <= (bpsc_r2d_mv(cfg_level_r) != 11'h000)
                ? bpsc_r2d_mv(cfg_level_r) : FB_REF_MV;
            reserved_r <= (cfg_level_r == R2D_RESERVED);
        end
    end

    // power-good: released only in soft start or run state while filtered window holds
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            pg_oe_r <= 1'b1;
        else
            pg_oe_r <= !(((state_r == ST_RAMP) || (state_r == ST_RUN)) && pg_filt);
    end

    // open-drain pins only ever pull low
    assign scl_o = 1'b0;
    assign scl_oe = 1'b0;
    assign sda_o = 1'b0;
    assign sda_oe = sda_low_r;
    assign power_good_output_o = 1'b0;
    assign power_good_output_oe = pg_oe_r;
    assign switching_on = switching_on_r;
    assign discharge_on = discharge_on_r;
    assign soft_start_active = soft_start_r;
    assign thermal_shutdown_active = tsd_active_r;
    assign forced_pulse_width_operation = forced_pulse_width_operation_r;
    assign r2d_source_on = r2d_on_r;
    assign ea_ref_fixed = ea_fixed_r;
    assign ea_ref_mv = ea_mv_r;
    assign config_reserved = reserved_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence seq_hot_run;
        (state_r == ST_RUN) && tsd_s && en_s && !input_undervoltage_lockout_s && supply_s;
    endsequence
    sequence seq_tsd_entered;
        (state_r == ST_TSD) ##1 (!switching_on && discharge_on && thermal_shutdown_active);
    endsequence

    a_tsd_entry_halts: assert property (seq_hot_run |=> seq_tsd_entered)
        else $error("hot converter did not halt with discharge");
    a_tsd_resume_ramp: assert property ((state_r == ST_TSD) && rel_s && en_s && !input_undervoltage_lockout_s
        && supply_s |=> (state_r == ST_RAMP) && (timer_r == 24'h00_0000))
        else $error("cooled converter did not restart soft start");
    a_tsd_keeps_regs: assert property ((state_r == ST_TSD) && !reg_clear && !wr_stb
        |=> $stable(vout_code_r) && $stable(ctrl_r))
        else $error("register changed in thermal shutdown");
    a_warn_flag_set: assert property (variant_s && warn_s |=> warn_flag_r)
        else $error("warning flag not set");
    a_enable_low_off: assert property (!en_s |=> (state_r == ST_OFF) ##1 !switching_on)
        else $error("disabled converter kept switching");
    a_discharge_cases: assert property (!en_s || input_undervoltage_lockout_s || (state_r == ST_TSD)
        |=> discharge_on)
        else $error("discharge not active");
    a_pg_low_off: assert property ((state_r == ST_OFF) || (state_r == ST_TSD)
        |=> power_good_output_oe)
        else $error("power-good released while off");
    a_pg_window: assert property ((state_r == ST_RUN) && $past(state_r == ST_RUN)
        |-> power_good_output_oe == !$past(pg_filt))
        else $error("power-good does not follow window");
    a_r2d_source_off: assert property ((state_r == ST_RAMP) || (state_r == ST_RUN)
        |-> !r2d_source_on)
        else $error("sensing source still on after decoding");
    a_cfg_held: assert property ((state_r != ST_OFF) && $past(state_r != ST_OFF)
        && cfg_valid_r && $past(cfg_valid_r) |-> $stable(cfg_level_r))
        else $error("latched configuration changed");
    a_forced_pulse_width_operation_pin: assert property ((state_r == ST_RUN) && !variant_s
        |=> forced_pulse_width_operation == $past(vsel_s))
        else $error("mode does not follow select pin");
    a_regs_default: assert property (!supply_s |=> (vout_code_r == VOUT_RESET)
        && (ctrl_r == CTRL_RESET))
        else $error("registers not at defaults after supply loss");
endmodule
`default_nettype wire

/* verification/bpsc_i2c_ctrl.sv */
// bus controller model, open drain on both lines
`timescale 1ns/10ps
`default_nettype none
module bpsc_i2c_ctrl (
    // clock
    input wire logic ref_clk,
    // bus
    input wire logic sda,
    output logic scl_oe,
    output logic sda_oe
);
    int nacks = 0;
    // idle bus: both lines released, pulled high
    initial
    begin
        scl_oe = 0;
        sda_oe = 0;
    end
    task automatic hp();
        repeat (6) @(negedge ref_clk);
    endtask
    // start or repeated start made here
    task automatic st();
        sda_oe = 0;
        hp();
        scl_oe = 0;
        hp();
        sda_oe = 1;
        hp();
        scl_oe = 1;
    endtask
    // stop, bus released
    task automatic sp();
        sda_oe = 1;
        hp();
        scl_oe = 0;
        hp();
        sda_oe = 0;
        hp();
    endtask
    // nine clocks, msb first, data moved only while clock low
    task automatic xf(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--)
        begin
            sda_oe = !d[i];
            hp();
            scl_oe = 0;
            hp();
            q[i] = sda;
            scl_oe = 1;
            @(negedge ref_clk);
        end
    endtask
    // byte out, counts missing acks
    task automatic ab(input logic [7:0] b);
        logic [8:0] q;
        xf({b, 1'b1}, q);
        nacks += q[0];
    endtask
    task automatic wr(input logic [7:0] r, input logic [7:0] v);
        st();
        ab(8'h42);
        ab(r);
        ab(v);
        sp();
    endtask
    // read ends with controller nack
    task automatic rd(input logic [7:0] r, output logic [7:0] v);
        logic [8:0] q;
        st();
        ab(8'h42);
        ab(r);
        st();
        ab(8'h43);
        xf(9'h1FF, q);
        v = q[8:1];
        sp();
    endtask
endmodule
`default_nettype wire

/* verification/test_bpsc_power_ctrl.sv */
// testbench of the buck power state control block
`timescale 1ns/10ps
`default_nettype none
module test_bpsc_power_ctrl;
    logic ref_clk, reset_n, enable_pin, supply_above_1v8, input_undervoltage_lockout;
    logic temp_over_shutdown, temp_below_release, temp_over_warning, vout_in_window;
    logic voltage_select_mode_pin, variant_serial, scl_o, scl_oe, sda_o, sda_oe, c_scl, c_sda;
    logic switching_on, discharge_on, soft_start_active, thermal_shutdown_active;
    logic forced_pulse_width_operation, r2d_source_on, ea_ref_fixed, config_reserved;
    logic power_good_output_o, power_good_output_oe;
    logic [3:0] r2d_level;
    logic [10:0] ea_ref_mv;
    logic [7:0] v;
    wire scl_i = !(c_scl | scl_oe);
    wire sda_i = !(c_sda | sda_oe);
    int num_errors = 0;
    int n_tests = 0;
    // short enable delay and ramp
    bpsc_power_ctrl #(.DELAY_CYCLES(20), .RAMP_CYCLES(30)) dut (
        .ref_clk, .reset_n, .enable_pin, .supply_above_1v8, .input_undervoltage_lockout,
        .temp_over_shutdown, .temp_below_release, .temp_over_warning, .vout_in_window,
        .voltage_select_mode_pin, .variant_serial, .r2d_level, .scl_i, .scl_o, .scl_oe,
        .sda_i, .sda_o, .sda_oe, .switching_on, .discharge_on, .soft_start_active,
        .thermal_shutdown_active, .forced_pulse_width_operation, .r2d_source_on,
        .ea_ref_fixed, .ea_ref_mv, .config_reserved, .power_good_output_o,
        .power_good_output_oe
    );
    bpsc_i2c_ctrl ctl (.ref_clk, .sda(sda_i), .scl_oe(c_scl), .sda_oe(c_sda));
    task automatic cy(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
        n_tests++;
        if (s !== e)
        begin
            num_errors++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic test_done();
        if (num_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // clock and hang guard
    initial
    begin
        ref_clk = 0;
        forever #10 ref_clk = !ref_clk;
    end
    initial
    begin
        cy(30000);
        num_errors++;
        test_done();
    end
    // pin variant, then serial variant
    initial
    begin
        {enable_pin, input_undervoltage_lockout, temp_over_shutdown, reset_n} = 0;
        {temp_over_warning, vout_in_window, voltage_select_mode_pin, variant_serial} = 0;
        {supply_above_1v8, temp_below_release, r2d_level} = 6'h35;
        cy(4);
        reset_n = 1;
        cy(2);
        chk("dis pg", {discharge_on, power_good_output_oe}, 2'b11);
        enable_pin = 1;
        cy(10);
        chk("src", r2d_source_on, 1);
        cy(50);
        chk("src", r2d_source_on, 0);
        chk("ref", {ea_ref_fixed, ea_ref_mv}, 12'hABC);
        chk("od rsv", {scl_o, scl_oe, sda_o, power_good_output_o, config_reserved}, 5'h00);
        chk("sw dis", {switching_on, discharge_on}, 2'b10);
        {r2d_level, voltage_select_mode_pin, vout_in_window} = 6'h3F;
        cy(1650);
        chk("ref", ea_ref_mv, 11'h2BC);
        chk("pwm", forced_pulse_width_operation, 1);
        chk("pg", power_good_output_oe, 1);
        cy(100);
        chk("pg", power_good_output_oe, 0);
        {temp_over_shutdown, temp_below_release} = 2'b10;
        cy(6);
        chk("tsd", {thermal_shutdown_active, switching_on, discharge_on}, 3'b101);
        chk("pg", power_good_output_oe, 1);
        {temp_over_shutdown, temp_below_release} = 2'b01;
        cy(6);
        chk("ss", soft_start_active, 1);
        enable_pin = 0;
        cy(6);
        chk("off", {switching_on, discharge_on}, 2'b01);
        {variant_serial, enable_pin} = 2'b11;
        cy(60);
        ctl.rd(8'h01, v);
        chk("vout", v, 8'h64);
        chk("ref", ea_ref_mv, 11'h384);
        ctl.wr(8'h01, 8'h10);
        ctl.rd(8'h01, v);
        chk("vout", v, 8'h10);
        chk("pwm", forced_pulse_width_operation, 0);
        ctl.wr(8'h03, 8'h10);
        chk("pwm", forced_pulse_width_operation, 1);
        chk("ref", ea_ref_mv, 11'h1E0);
        ctl.rd(8'h02, v);
        chk("unmapped", v, 8'h00);
        temp_over_warning = 1;
        cy(6);
        chk("sw", switching_on, 1);
        input_undervoltage_lockout = 1;
        cy(6);
        chk("dis", discharge_on, 1);
        ctl.rd(8'h05, v);
        chk("status", v[1:0], 2'b11);
        {temp_over_warning, input_undervoltage_lockout, temp_over_shutdown} = 3'b001;
        cy(6);
        temp_over_shutdown = 0;
        cy(6);
        ctl.rd(8'h01, v);
        chk("vout", v, 8'h10);
        enable_pin = 0;
        cy(6);
        enable_pin = 1;
        cy(60);
        ctl.rd(8'h01, v);
        chk("vout", v, 8'h64);
        ctl.st();
        ctl.ab(8'h44);
        ctl.sp();
        chk("nacks", ctl.nacks, 1);
        test_done();
    end
endmodule
`default_nettype wire
